// *** core/usq_dev_end.sv ***
// burst sequencer device end: spi registers, tx burst, echo stop gating
// assumes link pins synchronous to i_sys_clk, which is also the reference clock
`timescale 1ns/1ps
`include "usq_regs.svh"
module usq_dev_end #(
    parameter int CNT_W = 5,
    parameter int DIV_W = 3,
    parameter int ECHO_W = 3
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    usq_link_if.dev lnk,
    input wire logic i_zero_cross,
    input wire logic i_over_thresh,
    output logic o_tx_drive,
    output logic o_tx_damp,
    output logic o_preamp_feedback_select,
    output logic o_preamp_cap_connect,
    output logic o_preamp_bypass,
    output logic o_preamp_power_on,
    output logic o_busy
);
    // ***************************
    // parameter check
    // ***************************
    // field positions are fixed, so wider fields would overlap
    if (CNT_W < 1 || CNT_W > 5 || DIV_W < 1 || DIV_W > 3 || ECHO_W < 1 || ECHO_W > 7)
    begin : g_bad_param
        $error("usq_dev_end: field width out of range");
    end

    function automatic logic [7:0] usq_half(input logic [DIV_W-1:0] e);
        usq_half = 8'h01 << e;
    endfunction

    // ***************************
    // spi slave and registers
    // ***************************
    logic [7:0] burst_r;
    logic [7:0] shape_r;
    logic [7:0] flight_r;
    logic [7:0] echo_r;
    logic sclk_q;
    logic [3:0] bit_cnt_r;
    logic [7:0] sh_r;
    logic cmd_rd_r;
    logic [6:0] cmd_addr_r;
    logic [7:0] rd_sh_r;
    logic miso_r;
    logic sclk_rise;
    logic sclk_fall;
    logic [6:0] rd_addr;
    logic [7:0] rd_val;
    usq_pkg::usq_dev_state_t state_r;
    logic [ECHO_W-1:0] echo_cnt_r;

    assign sclk_rise = lnk.spi_sclk & ~sclk_q & ~lnk.spi_cs_n;
    assign sclk_fall = ~lnk.spi_sclk & sclk_q & ~lnk.spi_cs_n;
    assign rd_addr = {sh_r[5:0], lnk.spi_mosi};

    always_comb
    begin
        rd_val = 8'h00;
        case (rd_addr)
            `USQ_ADDR_BURST: rd_val = burst_r;
            `USQ_ADDR_SHAPE: rd_val = shape_r;
            `USQ_ADDR_FLIGHT: rd_val = flight_r;
            `USQ_ADDR_ECHO: rd_val = echo_r;
            `USQ_ADDR_STATUS:
            begin
                rd_val[ECHO_W-1:0] = echo_cnt_r;
                rd_val[`USQ_BUSY_BIT] = (state_r != usq_pkg::USQ_DEV_IDLE);
            end
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sclk_q <= 1'b0;
            bit_cnt_r <= 4'h0;
            sh_r <= 8'h00;
            cmd_rd_r <= 1'b0;
            cmd_addr_r <= 7'h00;
            rd_sh_r <= 8'h00;
            miso_r <= 1'b0;
        end
        else
        begin
            sclk_q <= lnk.spi_sclk;
            if (lnk.spi_cs_n)
            begin
                bit_cnt_r <= 4'h0;
            end
            else if (sclk_rise)
            begin
                sh_r <= {sh_r[6:0], lnk.spi_mosi};
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (bit_cnt_r == `USQ_SPI_CMD_LAST)
                begin
                    cmd_rd_r <= sh_r[6];
                    cmd_addr_r <= rd_addr;
                    rd_sh_r <= rd_val;
                end
            end
            else if (sclk_fall && bit_cnt_r[3])
            begin
                miso_r <= rd_sh_r[7];
                rd_sh_r <= {rd_sh_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            burst_r <= `USQ_BURST_RST;
            shape_r <= `USQ_SHAPE_RST;
            flight_r <= `USQ_FLIGHT_RST;
            echo_r <= `USQ_ECHO_RST;
        end
        else if (sclk_rise && bit_cnt_r == `USQ_SPI_LAST_BIT && !cmd_rd_r)
        begin
            case (cmd_addr_r)
                `USQ_ADDR_BURST: burst_r <= {sh_r[6:0], lnk.spi_mosi};
                `USQ_ADDR_SHAPE: shape_r <= {sh_r[6:0], lnk.spi_mosi};
                `USQ_ADDR_FLIGHT: flight_r <= {sh_r[6:0], lnk.spi_mosi};
                `USQ_ADDR_ECHO: echo_r <= {sh_r[6:0], lnk.spi_mosi};
                default: ;
            endcase
        end
    end

    // ***************************
    // measurement sequencer
    // ***************************
    logic [DIV_W-1:0] div_exp;
    logic [CNT_W-1:0] cnt_cfg;
    logic [CNT_W-1:0] shift_pos;
    logic [ECHO_W-1:0] echo_lim;
    logic trig_q;
    logic zc_q;
    logic [7:0] ph_cnt_r;
    logic phase_r;
    logic [CNT_W-1:0] left_r;
    logic [CNT_W-1:0] idx_r;
    logic armed_r;
    logic fire;

    assign div_exp = burst_r[`USQ_DIV_LSB +: DIV_W];
    assign cnt_cfg = burst_r[`USQ_CNT_LSB +: CNT_W];
    assign shift_pos = shape_r[`USQ_SHIFT_LSB +: CNT_W];
    assign echo_lim = echo_r[`USQ_LIM_LSB +: ECHO_W];
    // zero-cross rise counts only once armed
    assign fire = (state_r == usq_pkg::USQ_DEV_LISTEN) & i_zero_cross & ~zc_q & armed_r;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            trig_q <= 1'b0;
            zc_q <= 1'b0;
        end
        else
        begin
            trig_q <= lnk.trigger;
            zc_q <= i_zero_cross;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= usq_pkg::USQ_DEV_IDLE;
            ph_cnt_r <= 8'h00;
            phase_r <= 1'b0;
            left_r <= '0;
            idx_r <= '0;
            armed_r <= 1'b0;
            echo_cnt_r <= '0;
        end
        else if (lnk.meas_reset || !lnk.enable)
        begin
            state_r <= usq_pkg::USQ_DEV_IDLE;
            armed_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                usq_pkg::USQ_DEV_IDLE:
                begin
                    if (lnk.trigger && !trig_q)
                    begin
                        state_r <= usq_pkg::USQ_DEV_BURST;
                        ph_cnt_r <= 8'h00;
                        phase_r <= 1'b0;
                        idx_r <= '0;
                        left_r <= (cnt_cfg == '0) ? CNT_W'(1) : cnt_cfg;
                        armed_r <= 1'b0;
                        echo_cnt_r <= '0;
                    end
                end
                usq_pkg::USQ_DEV_BURST:
                begin
                    if (ph_cnt_r == usq_half(div_exp) - 8'h01)
                    begin
                        ph_cnt_r <= 8'h00;
                        phase_r <= ~phase_r;
                        // one pulse ends per full period
                        if (phase_r)
                        begin
                            idx_r <= idx_r + CNT_W'(1);
                            left_r <= left_r - CNT_W'(1);
                            if (left_r == CNT_W'(1))
                            begin
                                state_r <= (echo_lim == '0) ? usq_pkg::USQ_DEV_IDLE :
                                    usq_pkg::USQ_DEV_LISTEN;
                            end
                        end
                    end
                    else
                    begin
                        ph_cnt_r <= ph_cnt_r + 8'h01;
                    end
                end
                usq_pkg::USQ_DEV_LISTEN:
                begin
                    // threshold arming wins over the clear by a fired event
                    armed_r <= i_over_thresh | (armed_r & ~fire);
                    // count forwarded echoes up to the limit
                    if (fire)
                    begin
                        echo_cnt_r <= echo_cnt_r + ECHO_W'(1);
                        if (echo_cnt_r + ECHO_W'(1) == echo_lim)
                        begin
                            state_r <= usq_pkg::USQ_DEV_IDLE;
                        end
                    end
                end
                default: state_r <= usq_pkg::USQ_DEV_IDLE;
            endcase
        end
    end

    // ***************************
    // registered outputs
    // ***************************
    logic start_r;
    logic stop_r;
    logic in_burst;
    logic invert;
    logic damp_now;

    assign in_burst = (state_r == usq_pkg::USQ_DEV_BURST);
    assign invert = (shift_pos != '0) && ({1'b0, idx_r} + 1'b1 >= {1'b0, shift_pos});
    assign damp_now = shape_r[`USQ_DAMP_BIT] && (left_r == CNT_W'(1));

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            start_r <= 1'b0;
            stop_r <= 1'b0;
            o_tx_drive <= 1'b0;
            o_tx_damp <= 1'b0;
            o_busy <= 1'b0;
        end
        else
        begin
            // start spans the first pulses, capped
            start_r <= in_burst && ({1'b0, idx_r} < (CNT_W + 1)'(`USQ_START_MAX_PERIODS));
            // tx shares the start register stage
            // high first half, low second half
            // phase inversion and damped last pulse
            o_tx_drive <= in_burst & ~damp_now & (~phase_r ^ invert);
            o_tx_damp <= in_burst & damp_now;
            // one-cycle stop pulse per qualified crossing
            stop_r <= fire;
            o_busy <= (state_r != usq_pkg::USQ_DEV_IDLE);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_preamp_feedback_select <= 1'b0;
            o_preamp_cap_connect <= 1'b1;
            o_preamp_bypass <= 1'b0;
            o_preamp_power_on <= 1'b1;
        end
        else
        begin
            o_preamp_feedback_select <= flight_r[`USQ_FB_BIT];
            o_preamp_cap_connect <= ~flight_r[`USQ_FB_BIT];
            o_preamp_bypass <= flight_r[`USQ_BYP_BIT];
            o_preamp_power_on <= ~flight_r[`USQ_BYP_BIT];
        end
    end

    assign lnk.start = start_r;
    assign lnk.stop = stop_r;
    assign lnk.spi_miso = miso_r;
endmodule

// *** core/usq_host_end.sv ***
// controller end: spi master, trigger with wait guards, flight timer
// assumes the device end on the same i_sys_clk
`timescale 1ns/1ps
`include "usq_regs.svh"
module usq_host_end #(
    parameter int TIME_W = 16,
    parameter int MEAS_WINDOW_CYC = 4095
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    usq_link_if.host lnk,
    input wire logic i_enable,
    input wire logic i_meas_reset,
    input wire logic i_measure_req,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [6:0] i_cmd_addr,
    input wire logic [7:0] i_cmd_wdata,
    output logic o_ready,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic [TIME_W-1:0] o_flight_time,
    output logic o_flight_valid
);
    if (TIME_W < 8 || MEAS_WINDOW_CYC < 1 || MEAS_WINDOW_CYC >= (1 << TIME_W))
    begin : g_bad_param
        $error("usq_host_end: window does not fit timer");
    end

    usq_pkg::usq_host_state_t state_r;
    logic [7:0] en_cnt_r;
    logic [7:0] rst_cnt_r;
    logic [1:0] half_r;
    logic [3:0] bit_r;
    logic [15:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic rd_r;
    logic [TIME_W-1:0] tmr_r;
    logic start_q;
    logic stop_q;
    logic may_trig;

    assign may_trig = (en_cnt_r >= 8'(`USQ_EN_TRIG_CYC)) && (rst_cnt_r >= 8'(`USQ_RES_TRIG_CYC));

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            en_cnt_r <= 8'h00;
            rst_cnt_r <= 8'h00;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            lnk.enable <= 1'b0;
            lnk.meas_reset <= 1'b1;
        end
        else
        begin
            lnk.enable <= i_enable;
            lnk.meas_reset <= i_meas_reset;
            start_q <= lnk.start;
            stop_q <= lnk.stop;
            en_cnt_r <= !lnk.enable ? 8'h00 : (en_cnt_r == 8'hff) ? en_cnt_r : en_cnt_r + 8'h01;
            rst_cnt_r <= lnk.meas_reset ? 8'h00 :
                (rst_cnt_r == 8'hff) ? rst_cnt_r : rst_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= usq_pkg::USQ_HOST_IDLE;
            half_r <= 2'h0;
            bit_r <= 4'h0;
            tx_sh_r <= 16'h0000;
            rx_sh_r <= 8'h00;
            rd_r <= 1'b0;
            tmr_r <= '0;
            lnk.trigger <= 1'b0;
            lnk.spi_sclk <= 1'b0;
            lnk.spi_cs_n <= 1'b1;
            lnk.spi_mosi <= 1'b0;
            o_ready <= 1'b0;
            o_rdata <= 8'h00;
            o_rdata_valid <= 1'b0;
            o_flight_time <= '0;
            o_flight_valid <= 1'b0;
        end
        else
        begin
            o_rdata_valid <= 1'b0;
            o_flight_valid <= 1'b0;
            case (state_r)
                usq_pkg::USQ_HOST_IDLE:
                begin
                    o_ready <= 1'b1;
                    if (i_cmd_valid && o_ready)
                    begin
                        state_r <= usq_pkg::USQ_HOST_SPI;
                        o_ready <= 1'b0;
                        tx_sh_r <= {~i_cmd_write, i_cmd_addr, i_cmd_wdata};
                        rd_r <= ~i_cmd_write;
                        lnk.spi_cs_n <= 1'b0;
                        lnk.spi_mosi <= ~i_cmd_write;
                        half_r <= 2'h0;
                        bit_r <= 4'h0;
                    end
                    else if (i_measure_req && o_ready && may_trig)
                    begin
                        state_r <= usq_pkg::USQ_HOST_TRIG;
                        o_ready <= 1'b0;
                        lnk.trigger <= 1'b1;
                    end
                end
                usq_pkg::USQ_HOST_SPI:
                begin
                    half_r <= half_r + 2'h1;
                    if (half_r == 2'(`USQ_SPI_HALF_CYC - 1))
                    begin
                        half_r <= 2'h0;
                        if (!lnk.spi_sclk)
                        begin
                            lnk.spi_sclk <= 1'b1;
                            rx_sh_r <= {rx_sh_r[6:0], lnk.spi_miso};
                        end
                        else
                        begin
                            lnk.spi_sclk <= 1'b0;
                            if (bit_r == `USQ_SPI_LAST_BIT)
                            begin
                                lnk.spi_cs_n <= 1'b1;
                                state_r <= usq_pkg::USQ_HOST_IDLE;
                                o_rdata <= rx_sh_r;
                                o_rdata_valid <= rd_r;
                            end
                            else
                            begin
                                bit_r <= bit_r + 4'h1;
                                tx_sh_r <= {tx_sh_r[14:0], 1'b0};
                                lnk.spi_mosi <= tx_sh_r[14];
                            end
                        end
                    end
                end
                usq_pkg::USQ_HOST_TRIG:
                begin
                    tmr_r <= '0;
                    if (lnk.start && !start_q)
                    begin
                        lnk.trigger <= 1'b0;
                        state_r <= usq_pkg::USQ_HOST_MEAS;
                    end
                    else if (lnk.meas_reset || !lnk.enable)
                    begin
                        lnk.trigger <= 1'b0;
                        state_r <= usq_pkg::USQ_HOST_IDLE;
                    end
                end
                usq_pkg::USQ_HOST_MEAS:
                begin
                    // interval from start rise to each stop rise
                    tmr_r <= tmr_r + TIME_W'(1);
                    if (lnk.stop && !stop_q)
                    begin
                        o_flight_time <= tmr_r;
                        o_flight_valid <= 1'b1;
                    end
                    if (tmr_r == TIME_W'(MEAS_WINDOW_CYC))
                    begin
                        state_r <= usq_pkg::USQ_HOST_IDLE;
                    end
                end
                default: state_r <= usq_pkg::USQ_HOST_IDLE;
            endcase
        end
    end
endmodule

// *** core/usq_link_if.sv ***
// link between the controller and the burst sequencer: control pins and spi
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface usq_link_if;
    logic trigger;
    logic enable;
    logic meas_reset;
    logic start;
    logic stop;
    logic spi_sclk;
    logic spi_cs_n;
    logic spi_mosi;
    logic spi_miso;

    modport dev
    (
        input trigger, enable, meas_reset, spi_sclk, spi_cs_n, spi_mosi,
        output start, stop, spi_miso
    );
    modport host
    (
        output trigger, enable, meas_reset, spi_sclk, spi_cs_n, spi_mosi,
        input start, stop, spi_miso
    );
endinterface

// *** core/usq_pkg.sv ***
// types shared by both ends of the ultrasonic burst sequencer link
// assumes nothing beyond a SystemVerilog compiler
package usq_pkg;
    typedef enum logic [2:0]
    {
        USQ_DEV_IDLE = 3'b001,
        USQ_DEV_BURST = 3'b010,
        USQ_DEV_LISTEN = 3'b100
    } usq_dev_state_t;

    typedef enum logic [3:0]
    {
        USQ_HOST_IDLE = 4'b0001,
        USQ_HOST_SPI = 4'b0010,
        USQ_HOST_TRIG = 4'b0100,
        USQ_HOST_MEAS = 4'b1000
    } usq_host_state_t;
endpackage

// *** core/usq_regs.svh ***
// constants of the ultrasonic burst sequencer: offsets, fields, resets, timing
// assumes a single 25 MHz system clock on both ends
`ifndef USQ_REGS_SVH
`define USQ_REGS_SVH
// ***************************
// timing
// ***************************
`define USQ_SYS_CLK_PERIOD_NS 40
`define USQ_EN_TRIG_WAIT_NS 50
`define USQ_RES_TRIG_WAIT_NS 3050
`define USQ_EN_TRIG_CYC \
    ((`USQ_EN_TRIG_WAIT_NS + `USQ_SYS_CLK_PERIOD_NS - 1) / `USQ_SYS_CLK_PERIOD_NS)
`define USQ_RES_TRIG_CYC \
    ((`USQ_RES_TRIG_WAIT_NS + `USQ_SYS_CLK_PERIOD_NS - 1) / `USQ_SYS_CLK_PERIOD_NS)
`define USQ_SPI_HALF_CYC 2
`define USQ_SPI_LAST_BIT 4'hf
`define USQ_SPI_CMD_LAST 4'h7
`define USQ_START_MAX_PERIODS 3
// ***************************
// register offsets
// ***************************
`define USQ_ADDR_BURST 7'h00
`define USQ_ADDR_SHAPE 7'h01
`define USQ_ADDR_FLIGHT 7'h02
`define USQ_ADDR_ECHO 7'h03
`define USQ_ADDR_STATUS 7'h04
// ***************************
// fields
// ***************************
`define USQ_DIV_LSB 5
`define USQ_CNT_LSB 0
`define USQ_DAMP_BIT 5
`define USQ_SHIFT_LSB 0
`define USQ_FB_BIT 1
`define USQ_BYP_BIT 0
`define USQ_LIM_LSB 0
`define USQ_BUSY_BIT 7
// ***************************
// reset values
// ***************************
`define USQ_BURST_RST 8'h41
`define USQ_SHAPE_RST 8'h00
`define USQ_FLIGHT_RST 8'h00
`define USQ_ECHO_RST 8'h01
`endif

// *** verification/testbench.sv ***
// testbench: both link ends joined, register, preamp and burst checks
// assumes the core files are compiled first
`timescale 1ns/1ps
`include "usq_regs.svh"
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1, mrst = 1'b1, req = 1'b0, zc = 1'b0, thr = 1'b0;
    logic valid = 1'b0, wr = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic tx, damp, fb, cap, byp, pwr, busy, rdy, rdv, fv;
    logic [7:0] rdata;
    logic [15:0] ftime;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] rq[$];
    logic [47:0] mq[$];
    logic [15:0] fq[$];
    logic [7:0] tx_n, half, sw, st_n, dmp, lo;
    logic tx_p = 1'b0, armed = 1'b0, st_p = 1'b0, sp_p = 1'b0;
    int ft = 0;
    usq_link_if usq_link_if_i ();
    usq_dev_end usq_dev_end_i (.i_sys_clk(clk), .i_reset_n(rst_n), .lnk(usq_link_if_i),
        .i_zero_cross(zc), .i_over_thresh(thr), .o_tx_drive(tx), .o_tx_damp(damp),
        .o_preamp_feedback_select(fb), .o_preamp_cap_connect(cap), .o_preamp_bypass(byp),
        .o_preamp_power_on(pwr), .o_busy(busy));
    usq_host_end #(.MEAS_WINDOW_CYC(200)) usq_host_end_i (.i_sys_clk(clk), .i_reset_n(rst_n),
        .lnk(usq_link_if_i), .i_enable(en), .i_meas_reset(mrst), .i_measure_req(req),
        .i_cmd_valid(valid), .i_cmd_write(wr), .i_cmd_addr(addr), .i_cmd_wdata(wdata),
        .o_ready(rdy), .o_rdata(rdata), .o_rdata_valid(rdv), .o_flight_time(ftime),
        .o_flight_valid(fv));
    usq_link_properties usq_link_properties_i (.i_sys_clk(clk), .i_reset_n(rst_n),
        .trigger(usq_link_if_i.trigger), .enable(usq_link_if_i.enable),
        .meas_reset(usq_link_if_i.meas_reset), .start(usq_link_if_i.start),
        .stop(usq_link_if_i.stop), .spi_sclk(usq_link_if_i.spi_sclk),
        .spi_cs_n(usq_link_if_i.spi_cs_n), .spi_mosi(usq_link_if_i.spi_mosi));
    // ***************************
    // tasks
    // ***************************
    task automatic end_of_test;
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_meas(input logic [47:0] g, input logic [47:0] e);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_ft(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // bounded wait; gives up silently after 1000 cycles if the host never idles
    task automatic wait_rdy;
        for (int n = 0; n < 1000 && rdy !== 1'b1; n++)
            step();
    endtask
    task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
        wait_rdy();
        valid = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        step();
        valid = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        rq.push_back(e);
        cmd(1'b0, a, 8'h00);
    endtask
    // ***************************
    // monitors
    // ***************************
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_of_test();
        end
        if (rdv === 1'b1)
            chk_rd(rdata, rq.pop_front());
        ft = (usq_link_if_i.start === 1'b1 && !st_p) ? 0 : ft + 1;
        if (usq_link_if_i.stop === 1'b1 && !sp_p)
            fq.push_back(16'(ft - 1));
        if (fv === 1'b1)
            chk_ft(ftime, fq.pop_front());
        st_p = (usq_link_if_i.start === 1'b1);
        sp_p = (usq_link_if_i.stop === 1'b1);
        if (busy === 1'b1 && !armed)
        begin
            armed = 1'b1;
            {tx_n, half, sw, st_n, dmp, lo} = 48'h0;
        end
        if (armed)
        begin
            tx_n += (tx === 1'b1 && !tx_p) ? 8'h01 : 8'h00;
            half += (tx_n == 8'h01 && tx === 1'b1) ? 8'h01 : 8'h00;
            sw += {7'h00, usq_link_if_i.start === 1'b1};
            st_n += {7'h00, usq_link_if_i.stop === 1'b1};
            dmp += {7'h00, damp === 1'b1};
            lo += (usq_link_if_i.start === 1'b1 && tx_n < 8'h02 && tx === 1'b0) ? 8'h01 : 8'h00;
        end
        tx_p = (tx === 1'b1);
        if (armed && rdy === 1'b1 && busy === 1'b0)
        begin
            armed = 1'b0;
            chk_meas({tx_n, half, sw, st_n, dmp, lo}, mq.pop_front());
        end
    end
    // ***************************
    // main sequence
    // ***************************
    initial
    begin
        int e, n, dm, lim, sp;
        void'($urandom(48858));
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        mrst = 1'b0;
        rd(`USQ_ADDR_BURST, `USQ_BURST_RST);
        rd(`USQ_ADDR_SHAPE, `USQ_SHAPE_RST);
        rd(`USQ_ADDR_ECHO, `USQ_ECHO_RST);
        rd(7'h05 + 7'($urandom % 100), 8'h00);
        for (int v = 0; v < 4; v++)
        begin
            cmd(1'b1, `USQ_ADDR_FLIGHT, 8'(v));
            rd(`USQ_ADDR_FLIGHT, 8'(v));
            chk_rd({4'h0, fb, cap, byp, pwr},
                {4'h0, v[1], ~v[1], v[0], ~v[0]});
        end
        for (int i = 0; i < 4; i++)
        begin
            e = $urandom % 3;
            n = 2 + $urandom % 4;
            dm = $urandom % 2;
            sp = $urandom % 3;
            lim = 1 + $urandom % 7;
            cmd(1'b1, `USQ_ADDR_BURST, {e[2:0], n[4:0]});
            cmd(1'b1, `USQ_ADDR_SHAPE, {2'b00, dm[0], sp[4:0]});
            cmd(1'b1, `USQ_ADDR_ECHO, {5'h00, lim[2:0]});
            // expected pulses, first half period, start width, stops, damp, low lead
            mq.push_back({8'(n - dm), 8'(1 << e), 8'((n < 3 ? n : 3) << (e + 1)), 8'(lim),
                8'(dm << (e + 1)),
                8'((n == 2 && dm == 1) ? 3 << e : (sp == 0 ? 1 << e : 2 << e))});
            wait_rdy();
            req = 1'b1;
            for (int t = 0; t < 200 && rdy === 1'b1; t++)
                step();
            req = 1'b0;
            for (int t = 0; t < 200 && usq_link_if_i.start !== 1'b1; t++)
                step();
            for (int t = 0; t < 200 && usq_link_if_i.start === 1'b1; t++)
                step();
            repeat (((n > 3) ? n - 3 : 0) << (e + 1))
                step();
            thr = 1'b1;
            repeat (2) step();
            repeat (lim + $urandom % 3)
            begin
                zc = 1'b1;
                repeat (2) step();
                zc = 1'b0;
                repeat (4) step();
            end
            thr = 1'b0;
            rd(`USQ_ADDR_STATUS, 8'(lim));
        end
        wait_rdy();
        repeat (4) step();
        end_of_test();
    end
endmodule

// *** verification/usq_link_properties.sv ***
// link checker: timing relations on the controller/sequencer pins
// assumes every link signal is sampled on i_sys_clk
`timescale 1ns/1ps
module usq_link_properties (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic trigger,
    input wire logic enable,
    input wire logic meas_reset,
    input wire logic start,
    input wire logic stop,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi
);
    // ***************************
    // helper and properties
    // ***************************
    logic [6:0] quiet_r;
    // cycles with meas_reset low, saturating
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            quiet_r <= 7'h00;
        else if (meas_reset)
            quiet_r <= 7'h00;
        else if (quiet_r != 7'h7f)
            quiet_r <= quiet_r + 7'h01;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    property p_trig_start; $rose(trigger) |-> ##[1:3] $rose(start); endproperty
    a_trig_start: assert property (p_trig_start) else $error("start late");
    property p_start_cause; $rose(start) |-> trigger; endproperty
    a_start_cause: assert property (p_start_cause) else $error("start no trigger");
    property p_trig_drop; $rose(start) |-> ##[1:2] !trigger; endproperty
    a_trig_drop: assert property (p_trig_drop) else $error("trigger held");
    property p_start_once; $fell(start) |=> !start [*8]; endproperty
    a_start_once: assert property (p_start_once) else $error("start twice");
    property p_stop_pulse; stop |=> !stop; endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("stop long");
    property p_stop_quiet; start |-> !stop; endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stop in burst");
    property p_en_wait; $rose(trigger) |-> enable && $past(enable); endproperty
    a_en_wait: assert property (p_en_wait) else $error("enable wait short");
    property p_rst_wait; $rose(trigger) |-> quiet_r >= 7'h4d; endproperty
    a_rst_wait: assert property (p_rst_wait) else $error("reset wait short");
    property p_sclk_idle; spi_cs_n |-> !spi_sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk outside frame");
    property p_sclk_hold; $changed(spi_sclk) |=> $stable(spi_sclk); endproperty
    a_sclk_hold: assert property (p_sclk_hold) else $error("sclk half short");
    property p_mosi_hold; spi_sclk |-> $stable(spi_mosi); endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved");
endmodule
